// file: core/osst_pkg.sv
// Package: register map, field layout and reset values of the oscillator select block
package osst_pkg;
    // Register byte offsets (Wishbone, one word each)
    localparam logic [7:0] OSST_OSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] OSST_REF_SEL_OFS = 8'h04;
    localparam logic [7:0] OSST_TRIM_COPY_OFS = 8'h08;
    localparam logic [7:0] OSST_STATUS_OFS = 8'h0c;
    // Oscillator control fields
    localparam int OSST_TRIM_LSB = 0;
    localparam int OSST_TRIM_W = 10;
    localparam int OSST_DRIVE_BIT = 10;
    localparam int OSST_BYPASS_BIT = 11;
    localparam int OSST_RELAX_PD_BIT = 12;
    localparam int OSST_EXT_PD_BIT = 13;
    // Reference select fields
    localparam int OSST_REFSEL_BIT = 0;
    // Status fields
    localparam int OSST_STAT_CUR_BIT = 0;
    localparam int OSST_STAT_BUSY_BIT = 1;
    // Reset values
    localparam logic [9:0] OSST_TRIM_RST = 10'h200;
    localparam logic OSST_DRIVE_RST = 1'b0;
    localparam logic OSST_BYPASS_RST = 1'b0;
    localparam logic OSST_REFSEL_RST = 1'b0;
    // Switch settling: edges of the target clock seen before handover
    localparam logic [1:0] OSST_SYNC_EDGES = 2'h2;

    typedef struct packed {
        logic [9:0] trim;
        logic driveLevel;
        logic bypass;
        logic relaxPowerDown;
        logic extPowerDown;
    } osst_osc_cfg_t;
endpackage : osst_pkg

// file: core/osst_clk_gate.sv
// One leg of the glitch-free clock switch
`timescale 1ns/10ps
`default_nettype none
module osst_clk_gate (
    // Leg clock and reset
    input wire logic legClk,
    input wire logic rst,
    // Control
    input wire logic wantThis,
    input wire logic otherOff,
    // Result
    output logic legOn
);
    import osst_pkg::*;
    logic sync1_reg;
    logic sync2_reg;
    // Two stages on the leg clock; enable only once the other leg is dark
    always_ff @(posedge legClk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= wantThis & otherOff;
            sync2_reg <= sync1_reg;
        end
    end
    // Negative-edge gate so the leg only opens or closes while its clock is low
    always_ff @(negedge legClk) begin
        if (rst) begin
            legOn <= 1'b0;
        end else begin
            legOn <= sync2_reg;
        end
    end
endmodule : osst_clk_gate
`default_nettype wire

// file: core/osst_oscillator_select.sv
// Reference clock select, oscillator configuration and relaxation trim
`timescale 1ns/10ps
`default_nettype none
module osst_oscillator_select (
    // System
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Factory calibration from information block
    input wire logic [9:0] factoryTrim,
    // Oscillator clocks
    input wire logic relaxClk,
    input wire logic extClk,
    // Oscillator controls
    output osst_pkg::osst_osc_cfg_t oscCfg,
    // Master reference clock
    output logic masterClk
);
    import osst_pkg::*;

    logic [9:0] trim_reg;
    logic driveLevel_reg;
    logic bypass_reg;
    logic relaxPd_reg;
    logic extPd_reg;
    logic refSel_reg;
    logic [9:0] trimCopy_reg;
    logic ack_reg;
    logic [31:0] rdData_reg;
    logic relaxOn;
    logic extOn;
    logic relaxOnS1_reg;
    logic relaxOnS2_reg;
    logic extOnS1_reg;
    logic extOnS2_reg;
    logic access;
    logic wrStrobe;

    assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wrStrobe = access & wb_we_i;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;

    // Single-cycle answer; ack drops the cycle after it is given
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    // Oscillator control word; drive level and powers are the software's job
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trim_reg <= OSST_TRIM_RST;
            driveLevel_reg <= OSST_DRIVE_RST;
            bypass_reg <= OSST_BYPASS_RST;
            relaxPd_reg <= 1'b0;
            extPd_reg <= 1'b0;
        end else if (wrStrobe && wb_adr_i == OSST_OSC_CTRL_OFS) begin
            if (wb_sel_i[0]) begin
                trim_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                trim_reg[9:8] <= wb_dat_i[9:8];
                driveLevel_reg <= wb_dat_i[OSST_DRIVE_BIT];
                bypass_reg <= wb_dat_i[OSST_BYPASS_BIT];
                relaxPd_reg <= wb_dat_i[OSST_RELAX_PD_BIT];
                extPd_reg <= wb_dat_i[OSST_EXT_PD_BIT];
            end
        end
    end

    // Reference select; software waits for stability before flipping it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            refSel_reg <= OSST_REFSEL_RST;
        end else if (wrStrobe && wb_adr_i == OSST_REF_SEL_OFS && wb_sel_i[0]) begin
            refSel_reg <= wb_dat_i[OSST_REFSEL_BIT];
        end
    end

    // Factory trim captured by clock while reset is held, never async
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trimCopy_reg <= factoryTrim;
        end
    end

    // Trim drives the capacitor bank directly, one step about 0.1%
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            oscCfg <= '{trim: OSST_TRIM_RST, driveLevel: OSST_DRIVE_RST, bypass: OSST_BYPASS_RST,
                        relaxPowerDown: 1'b0, extPowerDown: 1'b0};
        end else begin
            oscCfg <= '{trim: trim_reg, driveLevel: driveLevel_reg, bypass: bypass_reg,
                        relaxPowerDown: relaxPd_reg, extPowerDown: extPd_reg};
        end
    end

    // Glitch-free switch: each leg closes before the other opens
    osst_clk_gate relaxLeg (
        .legClk(relaxClk),
        .rst(sys_rst),
        .wantThis(~refSel_reg),
        .otherOff(~extOn),
        .legOn(relaxOn)
    );
    osst_clk_gate extLeg (
        .legClk(extClk),
        .rst(sys_rst),
        .wantThis(refSel_reg),
        .otherOff(~relaxOn),
        .legOn(extOn)
    );
    assign masterClk = (relaxClk & relaxOn) | (extClk & extOn);

    // Leg states brought to the bus clock for status
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            relaxOnS1_reg <= 1'b0;
            relaxOnS2_reg <= 1'b0;
            extOnS1_reg <= 1'b0;
            extOnS2_reg <= 1'b0;
        end else begin
            relaxOnS1_reg <= relaxOn;
            relaxOnS2_reg <= relaxOnS1_reg;
            extOnS1_reg <= extOn;
            extOnS2_reg <= extOnS1_reg;
        end
    end

    // Read mux; unmapped addresses read zero but still ack
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_reg <= 32'h0;
        end else if (access && !wb_we_i) begin
            if (wb_adr_i == OSST_OSC_CTRL_OFS) begin
                rdData_reg <= {18'h0, extPd_reg, relaxPd_reg, bypass_reg, driveLevel_reg, trim_reg};
            end else if (wb_adr_i == OSST_REF_SEL_OFS) begin
                rdData_reg <= {31'h0, refSel_reg};
            end else if (wb_adr_i == OSST_TRIM_COPY_OFS) begin
                rdData_reg <= {22'h0, trimCopy_reg};
            end else if (wb_adr_i == OSST_STATUS_OFS) begin
                // Busy while neither or the wrong leg is on; software polls it
                rdData_reg <= {30'h0, (extOnS2_reg != refSel_reg) | ~(extOnS2_reg | relaxOnS2_reg),
                               extOnS2_reg};
            end else begin
                rdData_reg <= 32'h0;
            end
        end
    end

    trim_reset_a: assert property (@(posedge sys_clk) $fell(sys_rst) |-> oscCfg.trim == OSST_TRIM_RST)
        else $error("trim not default after reset");
    drive_reset_a: assert property (@(posedge sys_clk) $fell(sys_rst) |-> !oscCfg.driveLevel && !refSel_reg)
        else $error("drive or select not cleared at reset");
    trim_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrStrobe && wb_adr_i == OSST_OSC_CTRL_OFS && wb_sel_i == 4'hf |-> ##2 oscCfg.trim == $past(wb_dat_i[9:0], 2))
        else $error("trim write not applied");
    sel_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrStrobe && wb_adr_i == OSST_REF_SEL_OFS && wb_sel_i[0] |=> refSel_reg == $past(wb_dat_i[0]))
        else $error("select write lost");
    legs_exclusive_a: assert property (@(posedge sys_clk) disable iff (sys_rst) !(relaxOnS2_reg && extOnS2_reg))
        else $error("both clock legs on");
    copy_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) $stable(trimCopy_reg))
        else $error("factory copy changed");
    ack_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    power_reset_a: assert property (@(posedge sys_clk) $fell(sys_rst) |-> !oscCfg.relaxPowerDown && !oscCfg.extPowerDown)
        else $error("oscillator powered down at reset");
    switch_ext_c: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(extOnS2_reg));
    switch_back_c: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(relaxOnS2_reg) && refSel_reg == 1'b0);
    trim_write_c: cover property (@(posedge sys_clk) disable iff (sys_rst) wrStrobe && wb_adr_i == OSST_OSC_CTRL_OFS);
endmodule : osst_oscillator_select
`default_nettype wire

// file: bench/osst_osc_source.sv
// Behavioural crystal or external clock source and relaxation oscillator
`timescale 1ns/10ps
`default_nettype none
module osst_osc_source #(
    parameter int EXT_HALF = 12,
    parameter int RELAX_HALF = 19
) (
    // Power controls
    input wire logic relaxPowerDown,
    input wire logic extPowerDown,
    // Clocks
    output logic relaxClk,
    output logic extClk
);
    // Both run from time zero; a powered-down source stands still low
    initial begin
        relaxClk = 1'b0;
        forever #(RELAX_HALF) relaxClk = relaxPowerDown ? 1'b0 : ~relaxClk;
    end
    initial begin
        extClk = 1'b0;
        forever #(EXT_HALF) extClk = extPowerDown ? 1'b0 : ~extClk;
    end
endmodule : osst_osc_source
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the oscillator select block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import osst_pkg::*;
    logic sys_clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, masterClk, relaxClk, extClk;
    logic [7:0] wbAdr;
    logic [31:0] wbDatI, wbDatO, rd;
    logic [9:0] factoryTrim;
    logic [3:0] wbSel, laneMask;
    osst_osc_cfg_t oscCfg;
    int mismatches, comparisons;
    realtime t0;

    osst_oscillator_select u_osst_oscillator_select (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .factoryTrim(factoryTrim), .relaxClk(relaxClk),
        .extClk(extClk), .oscCfg(oscCfg), .masterClk(masterClk));
    osst_osc_source u_osst_osc_source (.relaxPowerDown(oscCfg.relaxPowerDown),
        .extPowerDown(oscCfg.extPowerDown), .relaxClk(relaxClk), .extClk(extClk));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : checkVal
    // Classic cycle; request held until ack is seen
    task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= laneMask;
        wbDatI <= dat;
        do begin
            @(posedge sys_clk);
            #1;
        end while (wbAck !== 1'b1);
        rd = wbDatO;
        @(posedge sys_clk);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wbCycle
    task automatic wrCtrl(input logic [31:0] c);
        wbCycle(1'b1, OSST_OSC_CTRL_OFS, c);
        #1;
        checkVal("oscCfg", {18'h0, c[9:0], c[10], c[11], c[12], c[13]}, 32'(oscCfg));
        wbCycle(1'b0, OSST_OSC_CTRL_OFS, 32'h0);
        checkVal("ctrl", c, rd);
    endtask : wrCtrl
    task automatic period(input int per);
        repeat (3) @(posedge masterClk);
        t0 = $realtime;
        @(posedge masterClk);
        checkVal("masterPeriod", 32'(per), 32'($rtoi($realtime - t0)));
    endtask : period
    // Status lags, so wait before polling busy
    task automatic swRef(input logic s, input int per);
        wbCycle(1'b1, OSST_REF_SEL_OFS, {31'h0, s});
        repeat (4) @(posedge sys_clk);
        rd = 32'h2;
        for (int i = 0; i < 100 && rd[1] !== 1'b0; i++)
            wbCycle(1'b0, OSST_STATUS_OFS, 32'h0);
        checkVal("status", {31'h0, s}, rd);
        period(per);
    endtask : swRef

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {sys_rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI} = {4'h8, 40'h0};
        factoryTrim = 10'h15a;
        wbSel = 4'h0;
        laneMask = 4'hf;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        factoryTrim <= 10'h0a5;
        wbCycle(1'b0, OSST_OSC_CTRL_OFS, 32'h0);
        checkVal("ctrl", 32'h200, rd);
        checkVal("oscCfg", {18'h0, OSST_TRIM_RST, 4'h0}, 32'(oscCfg));
        wbCycle(1'b0, OSST_REF_SEL_OFS, 32'h0);
        checkVal("refSel", 32'h0, rd);
        period(38);
        wbCycle(1'b1, OSST_TRIM_COPY_OFS, 32'h0);
        wbCycle(1'b0, OSST_TRIM_COPY_OFS, 32'h0);
        checkVal("trimCopy", 32'h15a, rd);
        $display("test reset values done");
        wrCtrl(32'h3ff);
        wrCtrl(32'h15a);
        wrCtrl(32'h55a);
        wrCtrl(32'hd5a);
        wrCtrl(32'h15a);
        $display("test control fields done");
        swRef(1'b1, 24);
        swRef(1'b0, 38);
        wrCtrl(32'h215a);
        $display("test reference switch done");
        wbCycle(1'b1, 8'h10, 32'hffffffff);
        wbCycle(1'b0, 8'h10, 32'h0);
        checkVal("unmapped", 32'h0, rd);
        $display("test unmapped done");
        // Lane 0 reaches only the low trim byte, lane 1 the rest
        laneMask = 4'h1;
        wbCycle(1'b1, OSST_OSC_CTRL_OFS, 32'h3fa5);
        laneMask = 4'hf;
        wbCycle(1'b0, OSST_OSC_CTRL_OFS, 32'h0);
        checkVal("ctrlLane0", 32'h21a5, rd);
        laneMask = 4'h2;
        wbCycle(1'b1, OSST_OSC_CTRL_OFS, 32'h00ff);
        laneMask = 4'hf;
        wbCycle(1'b0, OSST_OSC_CTRL_OFS, 32'h0);
        checkVal("ctrlLane1", 32'h0a5, rd);
        checkVal("oscCfg", {18'h0, 10'h0a5, 4'h0}, 32'(oscCfg));
        $display("test byte lanes done");
        // Second reset mid-run must reload the new factory copy
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wbCycle(1'b0, OSST_TRIM_COPY_OFS, 32'h0);
        checkVal("trimCopy", 32'h0a5, rd);
        checkVal("oscCfg", {18'h0, OSST_TRIM_RST, 4'h0}, 32'(oscCfg));
        wbCycle(1'b0, OSST_REF_SEL_OFS, 32'h0);
        checkVal("refSel", 32'h0, rd);
        period(38);
        $display("test second reset done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
